// ===== pkg/spg_pkg.sv
// constants for the shared pin gpio ports block
package spg_pkg;
	// register word addresses in data space
	localparam logic [15:0] ADDR_SEL_A = 16'h7090;
	localparam logic [15:0] ADDR_SEL_B = 16'h7092;
	localparam logic [15:0] ADDR_PORT_A = 16'h7098;
	localparam logic [15:0] ADDR_PORT_B = 16'h709A;
	localparam logic [15:0] ADDR_PORT_C = 16'h709C;
	// implemented bit masks
	localparam logic [15:0] MASK_SEL_A = 16'hFF0F;
	localparam logic [15:0] MASK_SEL_B = 16'h00FD;
	localparam logic [15:0] MASK_PORT_A = 16'h0F0F;
	localparam logic [15:0] MASK_PORT_BC = 16'hFFFF;
	// reset value of every register
	localparam logic [15:0] RST_VAL = 16'h0000;
	// field positions
	localparam int DIR_LSB = 8;
	localparam int SEL_B_PORT_LSB = 8;
	// inverted select bits in second select register
	localparam logic [7:0] SEL_B_INV = 8'h0C;
	// clock output select pattern that keeps port c bit 1 as i/o
	localparam logic [1:0] CLKSEL_IO = 2'h0;
endpackage

// ===== hdl/spg_gpio.sv
// shared pin gpio ports: select, direction and data registers
// Operation
// - the five registers decode as 16-bit words at 7090h, 7092h, 7098h, 709Ah and 709Ch.
// - the first select register holds bits 15..8 and 3..0, bits 7..4 read zero.
// - a one in the first select register gives the pin to its peripheral, zero makes it port a or b i/o.
// - the second select register holds bits 0 and 7..2, the rest read zero.
// - second select bits 0 and 7..4 give the peripheral on one, bits 2 and 3 give port c i/o on one.
// - all implemented bits clear to zero at reset.
// - port a has direction bits 11..8 and data bits 3..0 only.
// - port b has direction bits 15..8 governing data bits 7..0.
// - port c has the same layout as port b.
// - direction zero leaves the pin undriven, direction one enables the driver.
// - with direction zero a data read returns the pin level.
// - with direction one the written data bit is driven on the pin.
// - data and direction act only while the pin is in i/o function, else the peripheral owns it.
// - port c bit 1 is i/o only when the clock output select bits are 00.
`timescale 1ns/100ps
`default_nettype none
module spg_gpio (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// processor data space access
	input wire logic [15:0] bus_addr_i,
	input wire logic bus_wr_i,
	input wire logic bus_rd_i,
	input wire logic [15:0] bus_wdata_i,
	output logic [15:0] bus_rdata_o,
	// clock output select bits from system control
	input wire logic [1:0] clock_output_select_bits_i,
	// pin levels from the pads
	input wire logic [3:0] port_a_pin_level_i,
	input wire logic [7:0] port_b_pin_level_i,
	input wire logic [7:0] port_c_pin_level_i,
	// pad drive for i/o function
	output logic [3:0] port_a_out_o,
	output logic [3:0] port_a_oe_o,
	output logic [7:0] port_b_out_o,
	output logic [7:0] port_b_oe_o,
	output logic [7:0] port_c_out_o,
	output logic [7:0] port_c_oe_o,
	// pin ownership: one where the peripheral owns the pin
	output logic [3:0] port_a_periph_o,
	output logic [7:0] port_b_periph_o,
	output logic [7:0] port_c_periph_o
);

	// ==========================================
	// register state
	logic [15:0] sel_a_q, sel_a_d;
	logic [15:0] sel_b_q, sel_b_d;
	logic [15:0] port_a_q, port_a_d;
	logic [15:0] port_b_q, port_b_d;
	logic [15:0] port_c_q, port_c_d;
	logic [15:0] rdata_q, rdata_d;
	logic [19:0] sync1_q, sync2_q;
	logic [1:0] clk_s1_q, clk_s2_q;
	logic [3:0] a_out_q, a_oe_q, a_per_q;
	logic [7:0] b_out_q, b_oe_q, b_per_q;
	logic [7:0] c_out_q, c_oe_q, c_per_q;
	logic [3:0] a_out_d, a_oe_d, a_per_d;
	logic [7:0] b_out_d, b_oe_d, b_per_d;
	logic [7:0] c_out_d, c_oe_d, c_per_d;
	logic [7:0] c_io;
	logic [3:0] a_lvl;
	logic [7:0] b_lvl, c_lvl;
	// merged port a byte, only the low nibble is implemented
	logic [7:0] a_rd;

	// merged data byte: pin level for inputs, latched value for outputs
	function automatic logic [7:0] spg_read_byte(input logic [7:0] dir, input logic [7:0] dat,
		input logic [7:0] lvl);
		spg_read_byte = (dir & dat) | (~dir & lvl);
	endfunction

	// ==========================================
	// input synchronisers
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_q <= 20'h00000;
			sync2_q <= 20'h00000;
			clk_s1_q <= 2'h0;
			clk_s2_q <= 2'h0;
		end else begin
			sync1_q <= {port_c_pin_level_i, port_b_pin_level_i, port_a_pin_level_i};
			sync2_q <= sync1_q;
			clk_s1_q <= clock_output_select_bits_i;
			clk_s2_q <= clk_s1_q;
		end
	end

	assign a_lvl = sync2_q[3:0];
	assign b_lvl = sync2_q[11:4];
	assign c_lvl = sync2_q[19:12];

	// ==========================================
	// register writes and reads
	always_comb begin
		sel_a_d = sel_a_q;
		sel_b_d = sel_b_q;
		port_a_d = port_a_q;
		port_b_d = port_b_q;
		port_c_d = port_c_q;
		rdata_d = 16'h0000;
		a_rd = spg_read_byte({4'h0, port_a_q[11:8]}, {4'h0, port_a_q[3:0]}, {4'h0, a_lvl});
		if (bus_wr_i) begin
			unique case (bus_addr_i)
				spg_pkg::ADDR_SEL_A: sel_a_d = bus_wdata_i & spg_pkg::MASK_SEL_A;
				spg_pkg::ADDR_SEL_B: sel_b_d = bus_wdata_i & spg_pkg::MASK_SEL_B;
				spg_pkg::ADDR_PORT_A: port_a_d = bus_wdata_i & spg_pkg::MASK_PORT_A;
				spg_pkg::ADDR_PORT_B: port_b_d = bus_wdata_i & spg_pkg::MASK_PORT_BC;
				spg_pkg::ADDR_PORT_C: port_c_d = bus_wdata_i & spg_pkg::MASK_PORT_BC;
				default: begin
				end
			endcase
		end
		if (bus_rd_i) begin
			unique case (bus_addr_i)
				spg_pkg::ADDR_SEL_A: rdata_d = sel_a_q;
				spg_pkg::ADDR_SEL_B: rdata_d = sel_b_q;
				spg_pkg::ADDR_PORT_A: rdata_d = {port_a_q[15:8], 4'h0, a_rd[3:0]};
				spg_pkg::ADDR_PORT_B: rdata_d = {port_b_q[15:8],
					spg_read_byte(port_b_q[15:8], port_b_q[7:0], b_lvl)};
				spg_pkg::ADDR_PORT_C: rdata_d = {port_c_q[15:8],
					spg_read_byte(port_c_q[15:8], port_c_q[7:0], c_lvl)};
				default: rdata_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sel_a_q <= spg_pkg::RST_VAL;
			sel_b_q <= spg_pkg::RST_VAL;
			port_a_q <= spg_pkg::RST_VAL;
			port_b_q <= spg_pkg::RST_VAL;
			port_c_q <= spg_pkg::RST_VAL;
			rdata_q <= 16'h0000;
		end else begin
			sel_a_q <= sel_a_d;
			sel_b_q <= sel_b_d;
			port_a_q <= port_a_d;
			port_b_q <= port_b_d;
			port_c_q <= port_c_d;
			rdata_q <= rdata_d;
		end
	end

	// ==========================================
	// pin function selection and drive
	always_comb begin
		// port c i/o: inverted pair 2,3; bit 1 from clock select
		c_io = ~(sel_b_q[7:0] ^ spg_pkg::SEL_B_INV);
		c_io[1] = (clk_s2_q == spg_pkg::CLKSEL_IO);
		a_per_d = sel_a_q[3:0];
		b_per_d = sel_a_q[15:8];
		c_per_d = ~c_io;
		a_oe_d = port_a_q[11:8] & ~a_per_d;
		b_oe_d = port_b_q[15:8] & ~b_per_d;
		c_oe_d = port_c_q[15:8] & c_io;
		a_out_d = port_a_q[3:0] & a_oe_d;
		b_out_d = port_b_q[7:0] & b_oe_d;
		c_out_d = port_c_q[7:0] & c_oe_d;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			a_out_q <= 4'h0;
			a_oe_q <= 4'h0;
			a_per_q <= 4'h0;
			b_out_q <= 8'h00;
			b_oe_q <= 8'h00;
			b_per_q <= 8'h00;
			c_out_q <= 8'h00;
			c_oe_q <= 8'h00;
			c_per_q <= 8'h00;
		end else begin
			a_out_q <= a_out_d;
			a_oe_q <= a_oe_d;
			a_per_q <= a_per_d;
			b_out_q <= b_out_d;
			b_oe_q <= b_oe_d;
			b_per_q <= b_per_d;
			c_out_q <= c_out_d;
			c_oe_q <= c_oe_d;
			c_per_q <= c_per_d;
		end
	end

	// outputs straight from flops
	assign bus_rdata_o = rdata_q;
	assign port_a_out_o = a_out_q;
	assign port_a_oe_o = a_oe_q;
	assign port_a_periph_o = a_per_q;
	assign port_b_out_o = b_out_q;
	assign port_b_oe_o = b_oe_q;
	assign port_b_periph_o = b_per_q;
	assign port_c_out_o = c_out_q;
	assign port_c_oe_o = c_oe_q;
	assign port_c_periph_o = c_per_q;

	// ==========================================
	// checks
	chk_sel_a_mask: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(sel_a_q[7:4] == 4'h0)) else $error("select a reserved bits set");
	chk_sel_b_mask: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(sel_b_q[15:8] == 8'h00 && sel_b_q[1] == 1'b0)) else $error("select b reserved bits set");
	chk_port_a_mask: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		((port_a_q & 16'hF0F0) == 16'h0000)) else $error("port a reserved bits set");
	chk_write_read_sel: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(bus_wr_i && bus_addr_i == spg_pkg::ADDR_SEL_A) ##1 (bus_rd_i && bus_addr_i == spg_pkg::ADDR_SEL_A)
		|=> (bus_rdata_o == ($past(bus_wdata_i, 2) & 16'hFF0F))) else $error("select a readback wrong");
	chk_periph_no_oe: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		((port_b_periph_o & port_b_oe_o) == 8'h00 && (port_c_periph_o & port_c_oe_o) == 8'h00))
		else $error("driver on while peripheral owns pin");
	chk_b_drive: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(port_b_q[8] && !sel_a_q[8]) |=> (port_b_oe_o[0] && port_b_out_o[0] == $past(port_b_q[0])))
		else $error("port b pin 0 not driven");
	chk_c_inverted: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(!sel_b_q[2]) |=> port_c_periph_o[2]) else $error("port c pin 2 not flag output");
	chk_c1_clock: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(clk_s2_q != 2'h0) |=> (port_c_periph_o[1] && !port_c_oe_o[1])) else $error("port c pin 1 not clock");
	chk_in_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(bus_rd_i && bus_addr_i == spg_pkg::ADDR_PORT_C && !port_c_q[12])
		|=> (bus_rdata_o[4] == $past(sync2_q[16]))) else $error("port c input read wrong");

	// ==========================================
	// further checks on ownership, drive and readback

	// port a driver never on while the converter owns the pin
	chk_a_periph_oe: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		((port_a_periph_o & port_a_oe_o) == 4'h0)) else $error("port a driver on while peripheral owns pin");

	// port a pin 0 driven with its latch when output and i/o
	chk_a_drive: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(port_a_q[8] && !sel_a_q[0]) |=> (port_a_oe_o[0] && port_a_out_o[0] == $past(port_a_q[0])))
		else $error("port a pin 0 not driven");

	// port c pin 0 driven with its latch when output and i/o
	chk_c_drive: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(port_c_q[8] && !sel_b_q[0]) |=> (port_c_oe_o[0] && port_c_out_o[0] == $past(port_c_q[0])))
		else $error("port c pin 0 not driven");

	// port a pin 0 stays released while it is an input
	chk_a_in_undriven: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(!port_a_q[8]) |=> (!port_a_oe_o[0])) else $error("port a input pin driven");

	// all port b inputs stay released
	chk_b_in_undriven: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(port_b_q[15:8] == 8'h00) |=> (port_b_oe_o == 8'h00)) else $error("port b input pin driven");

	// port b drive value is low wherever the driver is off
	chk_out_gated: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		((port_b_out_o & ~port_b_oe_o) == 8'h00)) else $error("port b drive value without enable");

	// port b ownership follows the first select register high byte
	chk_b_periph_map: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		1'b1 |=> (port_b_periph_o == $past(sel_a_q[15:8]))) else $error("port b ownership wrong");

	// port a ownership follows the first select register low nibble
	chk_a_periph_map: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		1'b1 |=> (port_a_periph_o == $past(sel_a_q[3:0]))) else $error("port a ownership wrong");

	// second select bit 0 set hands port c pin 0 to the peripheral
	chk_c0_periph: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(sel_b_q[0]) |=> port_c_periph_o[0]) else $error("port c pin 0 not peripheral");

	// inverted bit 3 set keeps port c pin 3 as i/o
	chk_c3_io: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(sel_b_q[3]) |=> !port_c_periph_o[3]) else $error("port c pin 3 not i/o");

	// port c pin 1 is i/o while the clock select pattern is 00
	chk_c1_io: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(clk_s2_q == 2'h0) |=> !port_c_periph_o[1]) else $error("port c pin 1 not i/o");

	// a read of an unmapped word returns zero
	chk_unmapped_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(bus_rd_i && bus_addr_i == 16'h7094) |=> (bus_rdata_o == 16'h0000)) else $error("unmapped read not zero");

	// read data stands one cycle and falls back to zero
	chk_rdata_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(!bus_rd_i) |=> (bus_rdata_o == 16'h0000)) else $error("read data without read");

	// second select register reads back its stored value
	chk_sel_b_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(bus_rd_i && bus_addr_i == spg_pkg::ADDR_SEL_B) |=> (bus_rdata_o == $past(sel_b_q)))
		else $error("select b readback wrong");

	// port b input bit reads the synchronised pin level
	chk_b_in_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(bus_rd_i && bus_addr_i == spg_pkg::ADDR_PORT_B && !port_b_q[8])
		|=> (bus_rdata_o[0] == $past(sync2_q[4]))) else $error("port b input read wrong");

	// port a direction byte reads back as stored
	chk_a_dir_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(bus_rd_i && bus_addr_i == spg_pkg::ADDR_PORT_A)
		|=> (bus_rdata_o[15:8] == $past(port_a_q[15:8]))) else $error("port a direction readback wrong");
endmodule
`default_nettype wire

// ===== tb/spg_pin_model.sv
// external circuitry on the shared port pins
`timescale 1ns/100ps
`default_nettype none
module spg_pin_model (
	// pad drive from the block, port c over b over a
	input wire logic [19:0] out_i,
	input wire logic [19:0] oe_i,
	// level the outside world puts on a released pin
	input wire logic [19:0] ext_i,
	// resolved pin levels
	output logic [19:0] pin_o
);
	// a driven pin follows its driver, a released one the outside level
	always_comb begin
		for (int i = 0; i < 20; i++) begin
			pin_o[i] = oe_i[i] ? out_i[i] : ext_i[i];
		end
	end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the shared pin gpio ports
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [15:0] wd = 16'h0000;
	logic [1:0] cks = 2'h0;
	logic [19:0] ext = 20'h00000;
	logic [15:0] rdata;
	logic [3:0] ao, ae, ap;
	logic [7:0] bo, be, bp, co, ce, cp;
	logic [19:0] pin;
	int error_cnt = 0;
	int n_tests = 0;
	// =========================================
	// clock, partner and block
	initial begin
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	spg_pin_model pm_u (.out_i({co, bo, ao}), .oe_i({ce, be, ae}), .ext_i(ext), .pin_o(pin));
	spg_gpio dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_addr_i(addr), .bus_wr_i(wr),
		.bus_rd_i(rd), .bus_wdata_i(wd), .bus_rdata_o(rdata), .clock_output_select_bits_i(cks),
		.port_a_pin_level_i(pin[3:0]), .port_b_pin_level_i(pin[11:4]), .port_c_pin_level_i(pin[19:12]),
		.port_a_out_o(ao), .port_a_oe_o(ae), .port_b_out_o(bo), .port_b_oe_o(be),
		.port_c_out_o(co), .port_c_oe_o(ce), .port_a_periph_o(ap), .port_b_periph_o(bp),
		.port_c_periph_o(cp));
	// =========================================
	// shared tasks
	task chk(input logic [19:0] got, input logic [19:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task wr16(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk_sys_i);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk_sys_i);
		wr <= 1'b0;
	endtask
	task rdx(input logic [15:0] a, input logic [15:0] e);
		@(posedge clk_sys_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys_i);
		rd <= 1'b0;
		#1;
		chk({4'h0, rdata}, {4'h0, e});
	endtask
	// =========================================
	// scenarios
	task t_reset;
		rdx(spg_pkg::ADDR_SEL_A, 16'h0000);
		rdx(spg_pkg::ADDR_SEL_B, 16'h0000);
		rdx(spg_pkg::ADDR_PORT_A, 16'h0000);
		rdx(spg_pkg::ADDR_PORT_B, 16'h0000);
		rdx(spg_pkg::ADDR_PORT_C, 16'h0000);
		chk({cp, bp, ap}, 20'h0C000);
		chk({ce, be, ae}, 20'h00000);
		$display("reset test done");
	endtask
	task t_mask;
		wr16(spg_pkg::ADDR_SEL_A, 16'hFFFF);
		wr16(spg_pkg::ADDR_SEL_B, 16'hFFFF);
		wr16(spg_pkg::ADDR_PORT_A, 16'hFFFF);
		wr16(spg_pkg::ADDR_PORT_B, 16'hFFFF);
		wr16(spg_pkg::ADDR_PORT_C, 16'hFFFF);
		wr16(16'h7094, 16'hFFFF);
		rdx(spg_pkg::ADDR_SEL_A, 16'hFF0F);
		rdx(spg_pkg::ADDR_SEL_B, 16'h00FD);
		rdx(spg_pkg::ADDR_PORT_A, 16'h0F0F);
		rdx(spg_pkg::ADDR_PORT_B, 16'hFFFF);
		rdx(spg_pkg::ADDR_PORT_C, 16'hFFFF);
		rdx(16'h7094, 16'h0000);
		chk({cp, bp, ap}, 20'hF1FFF);
		chk({ce, be, ae}, 20'h0E000);
		chk({co, bo, ao}, 20'h0E000);
		$display("mask test done");
	endtask
	task t_drive;
		wr16(spg_pkg::ADDR_SEL_A, 16'h0000);
		wr16(spg_pkg::ADDR_SEL_B, 16'h000C);
		wr16(spg_pkg::ADDR_PORT_A, 16'h0F05);
		wr16(spg_pkg::ADDR_PORT_B, 16'hFFA5);
		wr16(spg_pkg::ADDR_PORT_C, 16'hFF3C);
		step(1);
		chk({co, bo, ao}, 20'h3CA55);
		chk({ce, be, ae}, 20'hFFFFF);
		rdx(spg_pkg::ADDR_PORT_B, 16'hFFA5);
		$display("drive test done");
	endtask
	task t_input;
		ext <= 20'hC35A6;
		wr16(spg_pkg::ADDR_PORT_B, 16'h00A5);
		wr16(spg_pkg::ADDR_PORT_C, 16'h0000);
		step(3);
		chk({ce, be}, 16'h0000);
		rdx(spg_pkg::ADDR_PORT_B, 16'h005A);
		rdx(spg_pkg::ADDR_PORT_C, 16'h00C3);
		$display("input test done");
	endtask
	task t_clksel;
		wr16(spg_pkg::ADDR_PORT_C, 16'h0202);
		cks <= 2'h1;
		step(4);
		chk({19'h0, cp[1]}, 20'h00001);
		chk({19'h0, ce[1]}, 20'h00000);
		cks <= 2'h0;
		step(4);
		chk({18'h0, ce[1], co[1]}, 20'h00003);
		$display("clock select test done");
	endtask
	task end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (3) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_mask();
		t_drive();
		t_input();
		t_clksel();
		end_of_test();
	end
	// watchdog well beyond the roughly 70 cycles the tests need
	initial begin
		#100000;
		error_cnt++;
		end_of_test();
	end
endmodule
`default_nettype wire
